// ==== hdl/smc_consts.svh ====
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

`define SMC_CTRL1_IDX 0
`define SMC_CTRL2_IDX 1
`define SMC_BGBUF_BIT 0
`define SMC_DET_EN_BIT 2
`define SMC_STOP_DET_BIT 3
`define SMC_WARN_LO_BIT 4
`define SMC_WARN_HI_BIT 5
`define SMC_TRIP_BIT 6
`define SMC_BGBUF_RST 1'b0
`define SMC_DET_EN_RST 1'b1
`define SMC_STOP_DET_RST 1'b1
`define SMC_TRIP_RST 1'b0
`define SMC_WARN_RST 2'b00
`define SMC_RESP_OKAY 2'b00
`define SMC_RESP_SLVERR 2'b10

`endif

// ==== hdl/smc_pkg.sv ====
package smc_pkg;
	typedef enum logic [1:0] {
		SMC_WARN_LOWEST = 2'b00,
		SMC_WARN_MID1 = 2'b01,
		SMC_WARN_MID2 = 2'b10,
		SMC_WARN_HIGHEST = 2'b11
	} smc_warn_lvl_t;

	typedef struct packed {
		logic detect_enable;
		logic stop_detect_enable;
		logic bandgap_buffer_enable;
		logic detect_trip_select;
		smc_warn_lvl_t warning_trip_select;
	} smc_ctrl_t;
endpackage : smc_pkg

// ==== hdl/smc_wonce.sv ====
`timescale 1ns/1ps
module smc_wonce #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [W-1:0] wr_data,
	output logic [W-1:0] q,
	output logic locked
);
	logic [W-1:0] val_q;
	logic done_q;
	wire take = wr_en & ~done_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			val_q <= RST_VAL;
			done_q <= 1'b0;
		end else begin
			if (take) begin
				val_q <= wr_data;
			end
			done_q <= done_q | wr_en;
		end
	end

	assign q = val_q;
	assign locked = done_q;
endmodule : smc_wonce

// ==== hdl/smc_regs.sv ====
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_regs #(
	parameter int ADDR_W = 8
) (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output smc_pkg::smc_ctrl_t CTRL_OUT
);
	import smc_pkg::*;

	localparam int IDX_W = ADDR_W - 2;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input int idx);
		reg_hit = (addr[ADDR_W-1:2] == IDX_W'(idx));
	endfunction : reg_hit

	function automatic logic [1:0] resp_of(input logic hit);
		resp_of = hit ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
	endfunction : resp_of

	// Reset released through two flops
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// Write channel: address and data captured in either order
	logic aw_full_q;
	logic w_full_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	wire aw_take = S_AXI_AWVALID & ~aw_full_q;
	wire w_take = S_AXI_WVALID & ~w_full_q;
	wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
	wire wr_hit1 = reg_hit(awaddr_q, `SMC_CTRL1_IDX);
	wire wr_hit2 = reg_hit(awaddr_q, `SMC_CTRL2_IDX);
	// Registers are one byte wide; only lane 0 carries them
	wire wr_lane0 = wr_go & wstrb_q[0];
	wire wr1 = wr_lane0 & wr_hit1;
	wire wr2 = wr_lane0 & wr_hit2;
	wire [1:0] wr_resp = resp_of(wr_hit1 | wr_hit2);

	always_ff @(posedge REF_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			aw_full_q <= 1'b0;
			awaddr_q <= '0;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				awaddr_q <= S_AXI_AWADDR;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			w_full_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (w_take) begin
				w_full_q <= 1'b1;
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// A pending response stalls the next write until BREADY
	always_ff @(posedge REF_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bvalid_q <= 1'b0;
			bresp_q <= `SMC_RESP_OKAY;
		end else begin
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_resp;
			end else if (S_AXI_BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign S_AXI_AWREADY = ~aw_full_q;
	assign S_AXI_WREADY = ~w_full_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;

	// Control fields
	logic det_en;
	logic trip_sel;
	logic stop_det_q;
	logic bgbuf_q;
	smc_warn_lvl_t warn_q;

	smc_wonce #(.W(1), .RST_VAL(`SMC_DET_EN_RST)) u_det_en (
		.clk(REF_CLK),
		.rst_n(rst_n_q),
		.wr_en(wr1),
		.wr_data(wdata_q[`SMC_DET_EN_BIT]),
		.q(det_en),
		.locked()
	);

	smc_wonce #(.W(1), .RST_VAL(`SMC_TRIP_RST)) u_trip (
		.clk(REF_CLK),
		.rst_n(rst_n_q),
		.wr_en(wr2),
		.wr_data(wdata_q[`SMC_TRIP_BIT]),
		.q(trip_sel),
		.locked()
	);

	always_ff @(posedge REF_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			stop_det_q <= `SMC_STOP_DET_RST;
			bgbuf_q <= `SMC_BGBUF_RST;
		end else begin
			if (wr1) begin
				stop_det_q <= wdata_q[`SMC_STOP_DET_BIT];
				bgbuf_q <= wdata_q[`SMC_BGBUF_BIT];
			end
		end
	end

	// Warning level stays writable after the trip select locks
	always_ff @(posedge REF_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			warn_q <= smc_warn_lvl_t'(`SMC_WARN_RST);
		end else begin
			if (wr2) begin
				warn_q <= smc_warn_lvl_t'(wdata_q[`SMC_WARN_HI_BIT:`SMC_WARN_LO_BIT]);
			end
		end
	end

	// Register images; unimplemented bits read zero
	wire [7:0] ctrl1_img = {4'h0, stop_det_q, det_en, 1'b0, bgbuf_q};
	wire [7:0] ctrl2_img = {1'b0, trip_sel, warn_q, 4'h0};

	// Analog-facing controls, registered
	smc_ctrl_t ctrl_d;
	smc_ctrl_t ctrl_q;
	assign ctrl_d.detect_enable = det_en;
	assign ctrl_d.stop_detect_enable = det_en & stop_det_q;
	assign ctrl_d.bandgap_buffer_enable = bgbuf_q;
	// Trip point only meaningful while the detector runs
	assign ctrl_d.detect_trip_select = det_en & trip_sel;
	assign ctrl_d.warning_trip_select = warn_q;

	always_ff @(posedge REF_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	assign CTRL_OUT = ctrl_q;

	// Read channel
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	wire ar_take = S_AXI_ARVALID & ~rvalid_q;
	wire rd_hit1 = reg_hit(S_AXI_ARADDR, `SMC_CTRL1_IDX);
	wire rd_hit2 = reg_hit(S_AXI_ARADDR, `SMC_CTRL2_IDX);
	wire [7:0] rd_byte = rd_hit1 ? ctrl1_img : (rd_hit2 ? ctrl2_img : 8'h00);
	wire [1:0] rd_resp = resp_of(rd_hit1 | rd_hit2);

	always_ff @(posedge REF_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `SMC_RESP_OKAY;
		end else begin
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q <= {24'h00_0000, rd_byte};
				rresp_q <= rd_resp;
			end else if (S_AXI_RREADY) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign S_AXI_ARREADY = ~rvalid_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;
endmodule : smc_regs

// ==== verification/smc_regs_sva.sv ====
`timescale 1ns/1ps
module smc_regs_sva (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire smc_pkg::smc_ctrl_t CTRL_OUT
);
	import smc_pkg::*;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	logic fell_q;
	// A cleared enable may never come back before reset
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) fell_q <= 1'b0;
		else if ($fell(CTRL_OUT.detect_enable)) fell_q <= 1'b1;
	end
	sequence s_r_wait;
		S_AXI_RVALID && !S_AXI_RREADY;
	endsequence
	a_det_once: assert property (fell_q |-> !CTRL_OUT.detect_enable)
		else $error("detect enable changed again");
	a_stop_gate: assert property (CTRL_OUT.stop_detect_enable |-> CTRL_OUT.detect_enable)
		else $error("stop detect not gated");
	a_trip_gate: assert property (CTRL_OUT.detect_trip_select |-> CTRL_OUT.detect_enable)
		else $error("trip select not gated");
	a_rd_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_rd_hold: assert property (s_r_wait |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("address taken during read");
	a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
endmodule : smc_regs_sva

bind smc_regs smc_regs_sva u_sva (.*);

// ==== verification/supply_monitor_control_regs_bench.sv ====
`timescale 1ns/1ps
module supply_monitor_control_regs_bench;
	import smc_pkg::*;
	logic REF_CLK = 0, RESET_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
	logic S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
	logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, a;
	logic [2:0] S_AXI_AWPROT = 0, S_AXI_ARPROT = 0;
	logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, rv, d;
	logic [3:0] S_AXI_WSTRB = 0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, de, hs;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
	smc_ctrl_t CTRL_OUT;
	int n_fail = 0, checks = 0, cyc = 0, m1, m2, lk1, lk2;
	smc_regs u_smc_regs (.*);
	always #2 REF_CLK = ~REF_CLK;
	task end_sim;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] st);
		@(posedge REF_CLK);
		S_AXI_AWADDR <= ad;
		S_AXI_WDATA <= dt;
		S_AXI_WSTRB <= st;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		// Late ready exercises the response hold
		S_AXI_BREADY <= 1'($urandom_range(1));
		do begin
			@(posedge REF_CLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
			hs = S_AXI_BVALID && S_AXI_BREADY;
			S_AXI_BREADY <= !hs && (S_AXI_BREADY || $urandom_range(1) == 1);
		end while (!hs);
		rs = S_AXI_BRESP;
	endtask : wr
	task rd(input logic [7:0] ad);
		@(posedge REF_CLK);
		S_AXI_ARADDR <= ad;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'($urandom_range(1));
		do begin
			@(posedge REF_CLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
			hs = S_AXI_RVALID && S_AXI_RREADY;
			S_AXI_RREADY <= !hs && (S_AXI_RREADY || $urandom_range(1) == 1);
		end while (!hs);
		rv = S_AXI_RDATA;
		rs = S_AXI_RRESP;
	endtask : rd
	task op(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] st);
		logic [1:0] e;
		e = (ad > 4) ? 2'b10 : 2'b00;
		wr(ad, dt, st);
		chk("bresp", rs, e);
		// Lane 0 strobe low leaves both value and lock alone
		if (st[0] && ad == 0) begin
			m1 = (dt & 9) | (lk1 ? m1 & 4 : dt & 4);
			lk1 = 1;
		end
		if (st[0] && ad == 4) begin
			m2 = (dt & 'h30) | (lk2 ? m2 & 'h40 : dt & 'h40);
			lk2 = 1;
		end
		rd(ad);
		chk("rdata", rv, ad == 0 ? m1 : ad == 4 ? m2 : 0);
		chk("rresp", rs, e);
		@(negedge REF_CLK);
		de = m1[2];
		chk("ctrl", CTRL_OUT, {de, de & m1[3], m1[0], de & m2[6], m2[5:4]});
	endtask : op
	initial begin
		void'($urandom(78));
		// Second pass proves reset reopens the write-once fields
		for (int p = 0; p < 2; p++) begin
			if (p > 0) @(posedge REF_CLK);
			RESET_N <= 1'b0;
			repeat (4) @(posedge REF_CLK);
			RESET_N <= 1'b1;
			m1 = 'h0C;
			m2 = 0;
			lk1 = 0;
			lk2 = 0;
			repeat (4) @(posedge REF_CLK);
			@(negedge REF_CLK);
			chk("ctrl_rst", CTRL_OUT, 32'h0000_0030);
			for (int i = 0; i < 12; i++) begin
				d = $urandom;
				d[5:4] = i[2:1];
				if (i == 0) d[2] = p[0];
				a = i[0] ? 8'h04 : (i % 4 == 2 ? 8'h08 : 8'h00);
				op(a, d, (i == 4) ? 4'h0 : 4'hF);
			end
		end
		end_sim();
	end
endmodule : supply_monitor_control_regs_bench
